/* hdl/dram_refresh_pkg.sv */
// Package with constants and types shared by the memory control and refresh logic.
package dram_refresh_pkg;
   // Clock rate and derived cycle counts.
   localparam int CLK_PERIOD_NS = 100;
   localparam int TICK_PERIOD_US = 30;
   localparam int TICK_CYCLES = (TICK_PERIOD_US * 1000) / CLK_PERIOD_NS;
   localparam int REFRESH_INTERVAL_MS = 2;
   localparam int INTERVAL_CYCLES = (REFRESH_INTERVAL_MS * 1000000) / CLK_PERIOD_NS;
   localparam int STEAL_MAX_NS = 31200;
   localparam int STEAL_MAX_CYCLES = STEAL_MAX_NS / CLK_PERIOD_NS;
   // Row counts for the two supported part sizes.
   localparam int ROWS_4K = 64;
   localparam int ROWS_16K = 128;
   localparam int ROW_W = 7;
   localparam int GRANT_CYCLES = 2;
   localparam logic [1:0] GRANT_LAST = 2'h1;
   // Refresh mode selection.
   typedef enum logic [1:0] {
      MODE_BLOCK = 2'h0,
      MODE_STEAL = 2'h1,
      MODE_TRANSPARENT = 2'h2,
      MODE_NONE = 2'h3
   } refresh_mode_t;
endpackage

/* hdl/refresh_timer.sv */
// Free-running period timer that emits one-cycle ticks.
`timescale 1ns/1ps
`default_nettype none
module refresh_timer #(
   parameter int PERIOD = 300
) (
   input wire logic i_clk, // System clock.
   input wire logic i_rst, // Synchronous reset, active high.
   output logic o_tick // One-cycle pulse each period.
);
   import dram_refresh_pkg::*;
   logic [23:0] count_reg;
   logic [23:0] count_next;
   logic tick_reg;
   logic tick_next;

   // Count down and reload; the tick marks the reload cycle.
   always_comb begin
      if (count_reg == 24'h0) begin
         count_next = 24'(PERIOD - 1);
         tick_next = 1'b1;
      end else begin
         count_next = count_reg - 24'h1;
         tick_next = 1'b0;
      end
   end

   // Registers only; reset restarts the period.
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         count_reg <= 24'h0;
         tick_reg <= 1'b0;
      end else begin
         count_reg <= count_next;
         tick_reg <= tick_next;
      end
   end

   assign o_tick = tick_reg;
endmodule
`default_nettype wire

/* hdl/dram_timing_unit.sv */
// Dynamic memory chip-enable timing shared by processor and refresh cycles.
`timescale 1ns/1ps
`default_nettype none
module dram_timing_unit (
   input wire logic i_clk, // System clock.
   input wire logic i_rst, // Synchronous reset, active high.
   input wire logic i_cpu_cycle, // Processor access to dynamic memory.
   input wire logic i_refresh_cycle, // Refresh cycle in progress.
   output logic o_chip_enable, // Dynamic RAM chip enable, active high.
   output logic o_refresh_select // High when the row mux shows the refresh row.
);
   import dram_refresh_pkg::*;
   logic ce_reg;
   logic ce_next;
   logic sel_reg;
   logic sel_next;

   // One enable source for both kinds of cycle; refresh wins the mux.
   always_comb begin
      ce_next = i_cpu_cycle | i_refresh_cycle;
      sel_next = i_refresh_cycle;
   end

   // Registers only.
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         ce_reg <= 1'b0;
         sel_reg <= 1'b0;
      end else begin
         ce_reg <= ce_next;
         sel_reg <= sel_next;
      end
   end

   assign o_chip_enable = ce_reg;
   assign o_refresh_select = sel_reg;
endmodule
`default_nettype wire

/* hdl/dram_refresh_controller.sv */
// Memory select decode and dynamic RAM refresh control for a 16-bit processor bus.
//
// Summary of operation
// R1: Top address bit low selects EPROM, high RAM.
// R2: EPROM select qualified by read direction.
// R3: RAM selected by cycle strobe; write, output gated. Code gates only output enable; write select follows write strobe.
// R4: Processor asserts write three phases after address.
// R5: Processor drops write one phase before address.
// R6: 4K parts: all 64 rows per 2 ms.
// R7: 16K parts: 128 rows per interval.
// R8: Refresh column address is arbitrary.
// R9: Refresh optional when accesses cover all rows.
// R10: Block mode halts processor, refreshes all rows.
// R11: Steal mode one row per steal, 31.2 us.
// R12: Timer ticks every 30 microseconds.
// R13: Request holds until refresh cycle completes.
// R14: Grant in first idle dynamic-memory clock.
// R15: Granted refresh lasts two clock cycles.
// R16: Access in second clock drives ready low. The code drops ready in the second grant clock for an access seen in the first.
// R17: Row address from incrementing modulo counter.
// R18: One timing unit for both cycle kinds.
// R19: Processor does at most three consecutive cycles.
// R20: Refresh request blocks bus hold grant.
// R21: Transparent: strobe rise before non-memory starts refresh.
// R22: Optional interval limit stops extra refreshes.
// R23: Processor drives strobe and read direction properly.
// R24: Reset clears counter, request, grant, timer.
// R25: Static mode input picks one request path.
`timescale 1ns/1ps
`default_nettype none
module dram_refresh_controller #(
   parameter int ROWS = dram_refresh_pkg::ROWS_4K,
   parameter int TICK_CYCLES = dram_refresh_pkg::TICK_CYCLES,
   parameter int INTERVAL_CYCLES = dram_refresh_pkg::INTERVAL_CYCLES,
   parameter bit INTERVAL_LIMIT = 1'b0
) (
   input wire logic i_clk, // System clock, 10 MHz.
   input wire logic i_rst, // Synchronous reset, active high.
   input wire logic [1:0] i_mode, // Refresh mode, static.
   input wire logic i_addr_top_bit, // Most significant address bit, pin.
   input wire logic i_memory_cycle_strobe_n, // Memory cycle strobe, active low, pin.
   input wire logic i_read_direction, // High during memory reads, pin.
   input wire logic i_write_strobe_n, // Write strobe, active low, pin.
   input wire logic i_bus_hold_req, // DMA hold grant request from processor side.
   output logic o_eprom_select_n, // EPROM chip select, active low.
   output logic o_ram_select_n, // Static RAM chip select, active low.
   output logic o_ram_write_n, // Static RAM write select, active low.
   output logic o_ram_output_en, // RAM output drivers enable, active high.
   output logic o_dram_chip_enable, // Dynamic RAM chip enable.
   output logic o_dram_refresh_select, // Row mux shows refresh row.
   output logic [dram_refresh_pkg::ROW_W-1:0] o_refresh_row, // Refresh row address.
   output logic o_refresh_request, // Refresh request pending.
   output logic o_refresh_grant, // Refresh cycle granted.
   output logic o_ready, // Processor ready, low stalls.
   output logic o_hold_halt, // Halts processor during block refresh.
   output logic o_bus_hold_grant // Gated bus hold grant.
);
   import dram_refresh_pkg::*;

   // Two-stage synchronisers for the pin inputs; first stage feeds only the second.
   logic [3:0] sync1_reg;
   logic [3:0] sync2_reg;
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         sync1_reg <= 4'hf;
         sync2_reg <= 4'hf;
      end else begin
         sync1_reg <= {i_addr_top_bit, i_memory_cycle_strobe_n, i_read_direction,
                       i_write_strobe_n};
         sync2_reg <= sync1_reg;
      end
   end
   logic top_bit;
   logic strobe_n;
   logic rd_dir;
   logic wr_n;
   assign top_bit = sync2_reg[3];
   assign strobe_n = sync2_reg[2];
   assign rd_dir = sync2_reg[1];
   assign wr_n = sync2_reg[0];
   // Write timing relative to address is the processor's job and is not checked here. R4 R5

   // Static decode; the read gating keeps EPROM off the bus during writes.
   logic cycle_on;
   logic dram_access;
   assign cycle_on = ~strobe_n;
   assign dram_access = cycle_on & top_bit;
   logic eprom_sel_reg;
   logic ram_sel_reg;
   logic ram_wr_reg;
   logic ram_oe_reg;
   logic eprom_sel_next;
   logic ram_sel_next;
   logic ram_wr_next;
   logic ram_oe_next;
   always_comb begin
      eprom_sel_next = ~(cycle_on & ~top_bit & rd_dir); // R1 R2
      ram_sel_next = ~(cycle_on & top_bit); // R1 R3
      ram_wr_next = wr_n; // R3
      ram_oe_next = rd_dir & cycle_on & top_bit; // R3
   end
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         eprom_sel_reg <= 1'b1;
         ram_sel_reg <= 1'b1;
         ram_wr_reg <= 1'b1;
         ram_oe_reg <= 1'b0;
      end else begin
         eprom_sel_reg <= eprom_sel_next;
         ram_sel_reg <= ram_sel_next;
         ram_wr_reg <= ram_wr_next;
         ram_oe_reg <= ram_oe_next;
      end
   end

   // Periodic tick source.
   logic tick;
   refresh_timer #(.PERIOD(TICK_CYCLES)) u_timer (
      .i_clk(i_clk),
      .i_rst(i_rst), // R24
      .o_tick(tick) // R12
   );

   // Refresh sequencer state.
   typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_REFRESH, ST_BLOCK} seq_state_t;
   seq_state_t state_reg;
   seq_state_t state_next;
   logic req_reg;
   logic req_next;
   logic [1:0] phase_reg;
   logic [1:0] phase_next;
   logic [ROW_W-1:0] row_reg;
   logic [ROW_W-1:0] row_next;
   logic [8:0] block_left_reg;
   logic [8:0] block_left_next;
   logic stall_reg;
   logic stall_next;
   logic strobe_prev_reg;
   logic [24:0] ivl_reg;
   logic [24:0] ivl_next;
   logic [ROW_W:0] done_reg;
   logic [ROW_W:0] done_next;
   logic ivl_full;
   logic trans_start;
   logic block_tick;
   logic row_step;

   // Transparent start on strobe rise; interval limiter gates steal and transparent starts and every row step.
   assign trans_start = strobe_n & ~strobe_prev_reg; // R21
   assign ivl_full = INTERVAL_LIMIT && (done_reg >= (ROW_W+1)'(ROWS)); // R22
   assign block_tick = (ivl_reg == 25'h0); // R10
   assign row_step = (state_reg == ST_REFRESH && phase_reg == GRANT_LAST) ||
                     (state_reg == ST_BLOCK);

   // Next-state logic for the sequencer, counters and ready stall.
   always_comb begin
      state_next = state_reg;
      req_next = req_reg;
      phase_next = phase_reg;
      row_next = row_reg;
      block_left_next = block_left_reg;
      stall_next = 1'b0;
      ivl_next = (ivl_reg == 25'h0) ? 25'(INTERVAL_CYCLES - 1) : ivl_reg - 25'h1;
      done_next = (ivl_reg == 25'h0) ? '0 : done_reg;
      if (row_step && !ivl_full) begin
         // Wrap at the part's row count; column address is don't-care.
         row_next = (row_reg == ROW_W'(ROWS - 1)) ? '0 : row_reg + ROW_W'(1); // R6 R7 R8 R17
         done_next = done_reg + (ROW_W+1)'(1);
      end
      case (state_reg)
         ST_IDLE: begin
            if (i_mode == MODE_STEAL && tick && !ivl_full) begin // R25 R11
               req_next = 1'b1;
               state_next = ST_WAIT;
            end else if (i_mode == MODE_TRANSPARENT && trans_start && !ivl_full) begin
               req_next = 1'b1; // R21 R25
               state_next = ST_REFRESH;
               phase_next = '0;
            end else if (i_mode == MODE_BLOCK && block_tick) begin // R10 R25
               req_next = 1'b1;
               state_next = ST_BLOCK;
               block_left_next = 9'(ROWS * GRANT_CYCLES - 1);
            end
         end
         ST_WAIT: begin
            // Wait for a clock with no dynamic memory access.
            if (!dram_access) begin // R14 R19
               state_next = ST_REFRESH;
               phase_next = '0;
            end
         end
         ST_REFRESH: begin
            if (phase_reg == GRANT_LAST) begin // R15
               state_next = ST_IDLE;
               req_next = 1'b0; // R13
            end else begin
               phase_next = phase_reg + 2'h1;
               stall_next = dram_access; // R16
            end
         end
         ST_BLOCK: begin
            // Processor is halted; one row per two clocks over the whole array.
            if (block_left_reg == 9'h0) begin
               state_next = ST_IDLE;
               req_next = 1'b0;
            end else begin
               block_left_next = block_left_reg - 9'h1;
            end
         end
         default: state_next = ST_IDLE;
      endcase
      // Block mode steps a row only every second clock.
      if (state_reg == ST_BLOCK && block_left_reg[0] == 1'b0) begin
         row_next = row_reg;
         done_next = done_reg;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin // R24
         state_reg <= ST_IDLE;
         req_reg <= 1'b0;
         phase_reg <= '0;
         row_reg <= '0;
         block_left_reg <= '0;
         stall_reg <= 1'b0;
         strobe_prev_reg <= 1'b1;
         ivl_reg <= '0;
         done_reg <= '0;
      end else begin
         state_reg <= state_next;
         req_reg <= req_next;
         phase_reg <= phase_next;
         row_reg <= row_next;
         block_left_reg <= block_left_next;
         stall_reg <= stall_next;
         strobe_prev_reg <= strobe_n;
         ivl_reg <= ivl_next;
         done_reg <= done_next;
      end
   end

   // Shared chip-enable timing for both cycle sources.
   dram_timing_unit u_timing (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_cpu_cycle(dram_access), // R18
      .i_refresh_cycle(state_reg == ST_REFRESH || state_reg == ST_BLOCK), // R18
      .o_chip_enable(o_dram_chip_enable),
      .o_refresh_select(o_dram_refresh_select)
   );

   // With no mode selected the logic stays idle, relying on normal accesses. R9
   assign o_eprom_select_n = eprom_sel_reg;
   assign o_ram_select_n = ram_sel_reg;
   assign o_ram_write_n = ram_wr_reg;
   assign o_ram_output_en = ram_oe_reg;
   assign o_refresh_row = row_reg;
   assign o_refresh_request = req_reg;
   assign o_refresh_grant = (state_reg == ST_REFRESH); // R14
   assign o_ready = ~stall_reg; // R16
   assign o_hold_halt = (state_reg == ST_BLOCK); // R10
   assign o_bus_hold_grant = i_bus_hold_req & ~req_reg; // R20

   // Checks on the sequencer and the select decode.
   property p_grant_two;
      @(posedge i_clk) disable iff (i_rst)
         $rose(o_refresh_grant) |-> (o_refresh_grant && o_refresh_request)
            ##1 (o_refresh_grant && o_refresh_request && !req_next)
            ##1 (!o_refresh_grant && !o_refresh_request);
   endproperty
   a_grant_two: assert property (p_grant_two) else $error("grant not two cycles"); // R15
   // A pending request that is neither granted nor a block must still stand next clock.
   property p_req_hold;
      @(posedge i_clk) disable iff (i_rst)
         o_refresh_request && !o_refresh_grant && !o_hold_halt |=> o_refresh_request;
   endproperty
   a_req_hold: assert property (p_req_hold) else $error("request dropped early"); // R13
   property p_row_step;
      @(posedge i_clk) disable iff (i_rst)
         $fell(o_refresh_grant) && !ivl_full |-> o_refresh_row != $past(o_refresh_row, 2);
   endproperty
   a_row_step: assert property (p_row_step) else $error("row not advanced"); // R17
   property p_eprom_write;
      @(posedge i_clk) disable iff (i_rst) !$past(rd_dir) |-> o_eprom_select_n;
   endproperty
   a_eprom_write: assert property (p_eprom_write) else $error("eprom on during write"); // R2
   property p_hold_block;
      @(posedge i_clk) disable iff (i_rst) o_refresh_request |-> !o_bus_hold_grant;
   endproperty
   a_hold_block: assert property (p_hold_block) else $error("hold granted during refresh"); // R20
   property p_grant_idle;
      @(posedge i_clk) disable iff (i_rst)
         state_reg == ST_WAIT && !dram_access |=> o_refresh_grant;
   endproperty
   a_grant_idle: assert property (p_grant_idle) else $error("grant late"); // R14
   property p_ram_sel;
      @(posedge i_clk) disable iff (i_rst) $past(dram_access) |-> !o_ram_select_n;
   endproperty
   a_ram_sel: assert property (p_ram_sel) else $error("ram not selected"); // R3
   property p_tick_req;
      @(posedge i_clk) disable iff (i_rst)
         tick && i_mode == MODE_STEAL && state_reg == ST_IDLE && !ivl_full |=> o_refresh_request;
   endproperty
   a_tick_req: assert property (p_tick_req) else $error("tick ignored"); // R11
   // A stall is only allowed inside a grant and lasts a single clock.
   property p_ready_stall;
      @(posedge i_clk) disable iff (i_rst) !o_ready |-> o_refresh_grant ##1 o_ready;
   endproperty
   a_ready_stall: assert property (p_ready_stall) else $error("stall outside refresh"); // R16
   // The shared timing unit must follow every granted clock with a refresh enable.
   property p_refresh_ce;
      @(posedge i_clk) disable iff (i_rst)
         o_refresh_grant |=> o_dram_chip_enable && o_dram_refresh_select;
   endproperty
   a_refresh_ce: assert property (p_refresh_ce) else $error("refresh enable missing"); // R18
   c_steal: cover property (@(posedge i_clk) o_refresh_grant && i_mode == MODE_STEAL);
   c_stall: cover property (@(posedge i_clk) !o_ready);
   c_block: cover property (@(posedge i_clk) $fell(o_hold_halt));
endmodule
`default_nettype wire

/* bench/cpu_bus_model.sv */
// Processor bus model that runs memory cycles on the strobe, direction and write pins.
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_model (
   input wire logic i_clk, // System clock.
   output logic o_addr_top_bit, // Top address bit.
   output logic o_memory_cycle_strobe_n, // Cycle strobe, active low.
   output logic o_read_direction, // High on reads.
   output logic o_write_strobe_n // Write strobe, active low.
);
   // Idle bus levels at time zero.
   initial begin
      o_addr_top_bit = 1'b0;
      o_memory_cycle_strobe_n = 1'b1;
      o_read_direction = 1'b0;
      o_write_strobe_n = 1'b1;
   end
   // One cycle of n clocks, n at least 3; the write strobe spans one clock only.
   task automatic run_cycle(input logic top, input logic rd, input int n);
      @(posedge i_clk);
      o_addr_top_bit <= top;
      o_memory_cycle_strobe_n <= 1'b0;
      o_read_direction <= rd;
      @(posedge i_clk);
      o_write_strobe_n <= rd;
      @(posedge i_clk);
      o_write_strobe_n <= 1'b1;
      repeat (n - 2) @(posedge i_clk);
      // A released address bus must not keep its last value, so it flips.
      o_addr_top_bit <= ~top;
      o_memory_cycle_strobe_n <= 1'b1;
      o_read_direction <= 1'b0;
   endtask
endmodule
`default_nettype wire

/* bench/dram_refresh_controller_bench.sv */
// Self-checking bench for the memory select and refresh controller.
`timescale 1ns/1ps
`default_nettype none
module dram_refresh_controller_bench;
   import dram_refresh_pkg::*;
   localparam int TICK = 20;
   localparam int NROWS = ROWS_4K;
   logic i_clk, i_rst, i_bus_hold_req;
   logic [1:0] i_mode;
   logic top, stb_n, rd, we_n, eprom_n, ram_n, wr_n, oe, ce, rsel, req, gnt, rdy, halt, hgnt;
   logic [ROW_W-1:0] row;
   int error_cnt = 0;
   int checked = 0;
   int cycles = 0;

   dram_refresh_controller #(.ROWS(NROWS), .TICK_CYCLES(TICK), .INTERVAL_CYCLES(400)) u_dut (
      .i_clk(i_clk), .i_rst(i_rst), .i_mode(i_mode), .i_addr_top_bit(top),
      .i_memory_cycle_strobe_n(stb_n), .i_read_direction(rd), .i_write_strobe_n(we_n),
      .i_bus_hold_req(i_bus_hold_req), .o_eprom_select_n(eprom_n), .o_ram_select_n(ram_n),
      .o_ram_write_n(wr_n), .o_ram_output_en(oe), .o_dram_chip_enable(ce),
      .o_dram_refresh_select(rsel), .o_refresh_row(row), .o_refresh_request(req),
      .o_refresh_grant(gnt), .o_ready(rdy), .o_hold_halt(halt), .o_bus_hold_grant(hgnt));
   cpu_bus_model u_cpu (.i_clk(i_clk), .o_addr_top_bit(top), .o_memory_cycle_strobe_n(stb_n),
      .o_read_direction(rd), .o_write_strobe_n(we_n));

   // Clock at 10 MHz.
   initial begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end
   // A hang is cut short well beyond the fewer than two thousand cycles the run needs.
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 10000) begin
         error_cnt++;
         tally_and_finish();
      end
   end
   // Compares one value and reports a mismatch.
   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %0h seen %0h", name, exp, seen);
      end
   endtask
   // Prints the counts and the verdict, then ends the run.
   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Holds reset for 21 cycles in the given mode and checks the cleared outputs after the 20th.
   task automatic do_reset(input refresh_mode_t mode);
      i_mode <= mode;
      i_rst <= 1'b1;
      repeat (20) @(posedge i_clk);
      #1;
      chk("reset state", {req, gnt, rdy, eprom_n, ram_n, oe, halt, 1'b0}, 8'h38);
      chk("reset row", 8'(row), 8'h0);
      @(posedge i_clk);
      i_rst <= 1'b0;
   endtask
   // Waits a bounded time for the grant, or the request, to be seen high.
   task automatic wait_hi(input bit want_gnt, input int lim, output int n);
      n = 0;
      do begin
         @(posedge i_clk);
         #1;
         n++;
      end while ((want_gnt ? gnt : req) !== 1'b1 && n < lim);
      chk("wait for refresh", 8'(n < lim), 8'h1);
   endtask
   // Each select follows the top address bit and the cycle direction; no mode, no refresh.
   task automatic test_decode();
      int e, r, w, o, q, c;
      do_reset(MODE_NONE);
      for (int i = 0; i < 4; i++) begin
         e = 0; r = 0; w = 0; o = 0; q = 0; c = 0;
         fork
            u_cpu.run_cycle(i[1], i[0], 6);
            repeat (14) begin
               @(posedge i_clk);
               #1;
               e += int'(eprom_n === 1'b0);
               r += int'(ram_n === 1'b0);
               w += int'(wr_n === 1'b0);
               o += int'(oe === 1'b1);
               q += int'(req !== 1'b0);
               c += int'(ce === 1'b1 && rsel === 1'b0);
            end
         join
         chk("chip enable", 8'(c), (i > 1) ? 8'h6 : 8'h0);
         chk("eprom select", 8'(e), (i == 1) ? 8'h6 : 8'h0);
         chk("ram select", 8'(r), (i > 1) ? 8'h6 : 8'h0);
         if (i > 1) chk("ram write", 8'(w), (i == 2) ? 8'h1 : 8'h0);
         if (i > 1) chk("ram output", 8'(o), (i == 3) ? 8'h6 : 8'h0);
         chk("idle request", 8'(q), 8'h0);
      end
   endtask
   // Steals one row per tick, in sequence through a wrap, and blocks the hold grant.
   task automatic test_steal();
      int n;
      logic [ROW_W-1:0] r;
      do_reset(MODE_STEAL);
      i_bus_hold_req <= 1'b1;
      for (int k = 0; k <= NROWS; k++) begin
         wait_hi(1'b0, 3 * TICK, n);
         if (k > 0) chk("tick spacing", 8'(n), 8'(TICK - 3));
         r = row;
         chk("hold grant", 8'(hgnt), 8'h0);
         @(posedge i_clk);
         #1;
         chk("grant first", 8'({gnt, req}), 8'h3);
         @(posedge i_clk);
         #1;
         chk("grant second", 8'({gnt, req, rdy}), 8'h7);
         chk("refresh enable", 8'({rsel, ce}), 8'h3);
         @(posedge i_clk);
         #1;
         chk("grant end", 8'({gnt, req, hgnt}), 8'h1);
         chk("row", 8'(row), 8'((int'(r) + 1) % NROWS));
         chk("refresh enable end", 8'({rsel, ce}), 8'h3);
      end
   endtask
   // A long dynamic memory cycle delays the grant while the request stays pending.
   task automatic test_busy();
      int g = 0;
      int q = 0;
      int n;
      fork
         u_cpu.run_cycle(1'b1, 1'b1, 40);
         begin
            repeat (3) @(posedge i_clk);
            repeat (37) begin
               @(posedge i_clk);
               #1;
               g += int'(gnt !== 1'b0);
               q += int'(req === 1'b1);
            end
         end
      join
      chk("grant during access", 8'(g), 8'h0);
      chk("request pending", 8'(q > 0), 8'h1);
      wait_hi(1'b1, 10, n);
   endtask
   // An access that reaches the array in the first grant clock stalls the processor once.
   task automatic test_stall();
      do_reset(MODE_STEAL);
      fork
         u_cpu.run_cycle(1'b1, 1'b1, 3);
         begin
            repeat (3) @(posedge i_clk);
            #1;
            chk("stall first", 8'({gnt, req, rdy}), 8'h7);
            @(posedge i_clk);
            #1;
            chk("stall second", 8'({gnt, req, rdy}), 8'h6);
            @(posedge i_clk);
            #1;
            chk("stall end", 8'({gnt, req, rdy}), 8'h1);
         end
      join
   endtask
   // Each strobe rise before an idle cycle starts exactly one refresh.
   task automatic test_transparent();
      int n;
      do_reset(MODE_TRANSPARENT);
      for (int k = 1; k <= 2; k++) begin
         u_cpu.run_cycle(1'b0, 1'b1, 3);
         wait_hi(1'b1, 10, n);
         repeat (2) @(posedge i_clk);
         #1;
         chk("transparent end", 8'({gnt, req}), 8'h0);
         chk("transparent row", 8'(row), 8'(k));
      end
   endtask
   // A block halts the processor while every row is refreshed in turn.
   task automatic test_block();
      int h = 0;
      int m = 0;
      int c = 0;
      logic [ROW_W-1:0] p;
      do_reset(MODE_BLOCK);
      p = row;
      repeat (300) begin
         @(posedge i_clk);
         #1;
         h += int'(halt === 1'b1);
         m += int'(halt !== req);
         c += int'(row !== p);
         p = row;
      end
      chk("halt cycles", 8'(h), 8'(2 * NROWS));
      chk("halt request", 8'(m), 8'h0);
      chk("row steps", 8'(c), 8'(NROWS));
      chk("block row", 8'(row), 8'h0);
   endtask
   // Main sequence.
   initial begin
      i_rst = 1'b1;
      i_mode = MODE_NONE;
      i_bus_hold_req = 1'b0;
      test_decode();
      test_steal();
      test_busy();
      test_stall();
      test_transparent();
      test_block();
      tally_and_finish();
   end
endmodule
`default_nettype wire
